// *** src/cfa_pkg.sv ***
// constants, types and address helpers for the code flash access guard
// assumes one system clock and a single byte-wide backing memory
// How it works
// RL1: code flash spans 0x0000..0x3FFF of program space; other code addresses read zero.
// RL2: program table reads of 0x0000..0x00FF are blocked from software.
// RL3: data eeprom is its own space, 0x00..0x7F, one byte per access.
// RL4: user id area is read only for software; program or erase is ignored.
// RL5: code flash offers empty check, program, verify and erase besides read.
// RL6: writes overwrite old bytes directly, no erase needed first.
// RL7: external programmer uses a two-wire port: data line plus clock it drives.
// RL8: area select 00 none, 01 from 0x3E00, 10 from 0x3C00, 11 all code; the guard drops 11 writes and erases below 0x0100 yet sets iap_ok.
// RL9: a blocked table read answers zero, with no error; the guard answers a blocked iap read with zero and iap_ok low.
package cfa_pkg;

   // ----------------------------------------------------------------
   // memory map
   // ----------------------------------------------------------------
   localparam int unsigned CODE_BYTES = 16384;
   localparam int unsigned EE_BYTES = 128;
   localparam int unsigned UID_BYTES = 16;
   localparam int unsigned MEM_DEPTH = CODE_BYTES + EE_BYTES + UID_BYTES;
   localparam int unsigned MEM_AW = 15;
   localparam logic [15:0] CODE_LAST = 16'h3FFF;
   localparam logic [15:0] PROT_LAST = 16'h00FF;
   localparam logic [15:0] AREA_HALF_BASE = 16'h3E00;
   localparam logic [15:0] AREA_ONE_BASE = 16'h3C00;
   localparam logic [15:0] EE_LAST = 16'h007F;
   localparam logic [15:0] UID_LAST = 16'h000F;
   localparam logic [14:0] EE_BASE = 15'h4000;
   localparam logic [14:0] UID_BASE = 15'h4080;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] BLOCKED_VALUE = 8'h00;

   // ----------------------------------------------------------------
   // in-application write area select codes
   // ----------------------------------------------------------------
   localparam logic [1:0] AREA_NONE = 2'h0;
   localparam logic [1:0] AREA_HALF = 2'h1;
   localparam logic [1:0] AREA_ONE = 2'h2;
   localparam logic [1:0] AREA_ALL = 2'h3;

   // ----------------------------------------------------------------
   // programmer frame: command byte, address word, data byte, msb first
   // ----------------------------------------------------------------
   localparam logic [7:0] PCMD_WRITE_CODE = 8'h01;
   localparam logic [7:0] PCMD_READ_CODE = 8'h02;
   localparam logic [7:0] PCMD_ERASE_CODE = 8'h03;
   localparam logic [7:0] PCMD_WRITE_UID = 8'h04;
   localparam logic [7:0] PCMD_READ_UID = 8'h05;
   localparam logic [4:0] PROG_FRAME_LAST = 5'h1F;
   localparam logic [3:0] PROG_REPLY_BITS = 4'h8;

   typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_ERASE, OP_EMPTY, OP_VERIFY} cfa_op_t;
   typedef enum logic [1:0] {SP_CODE, SP_EE, SP_UID} cfa_space_t;
   typedef enum logic [1:0] {OWN_CPU, OWN_IAP, OWN_PROG} cfa_owner_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ANSWER, ST_GAP} cfa_state_t;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic in_space(input cfa_space_t sp, input logic [15:0] a);
      unique case (sp)
         SP_CODE: in_space = (a <= CODE_LAST);
         SP_EE: in_space = (a <= EE_LAST);
         default: in_space = (a <= UID_LAST);
      endcase
   endfunction : in_space

   function automatic logic iap_area_ok(input logic [15:0] a, input logic [1:0] sel);
      unique case (sel)
         AREA_NONE: iap_area_ok = 1'b0;
         AREA_HALF: iap_area_ok = (a >= AREA_HALF_BASE) && (a <= CODE_LAST);
         AREA_ONE: iap_area_ok = (a >= AREA_ONE_BASE) && (a <= CODE_LAST);
         default: iap_area_ok = (a <= CODE_LAST);
      endcase
   endfunction : iap_area_ok

   function automatic logic [14:0] mem_index(input cfa_space_t sp, input logic [15:0] a);
      unique case (sp)
         SP_CODE: mem_index = {1'b0, a[13:0]};
         SP_EE: mem_index = EE_BASE | {8'h00, a[6:0]};
         default: mem_index = UID_BASE | {11'h000, a[3:0]};
      endcase
   endfunction : mem_index

endpackage : cfa_pkg

// *** src/cfa_mem_if.sv ***
// byte access channel between the access guard and its backing memory
// assumes the memory answers a read on the following clock edge
`timescale 1ns/1ns
interface cfa_mem_if #(parameter int unsigned AW = 15);
   logic req;
   logic we;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output req, output we, output addr, output wdata, input rdata);
   modport mem (input req, input we, input addr, input wdata, output rdata);
endinterface : cfa_mem_if

// *** src/cfa_mem.sv ***
// byte array for code flash, eeprom and user id, registered read data
// assumes the controller issues at most one access per cycle
`timescale 1ns/1ns
module cfa_mem
   import cfa_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // access channel
   cfa_mem_if.mem port
);
   logic [7:0] cells [MEM_DEPTH];
   logic [7:0] rdata_q;

   // plain overwrite: no erase cycle before a write
   always_ff @(posedge core_clk_i)
   begin
      if (port.req && port.we)
      begin
         cells[port.addr] <= port.wdata; // RL6
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rdata_q <= 8'h00;
      end
      else if (port.req && !port.we)
      begin
         rdata_q <= cells[port.addr];
      end
   end

   assign port.rdata = rdata_q;

   property p_overwrite;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (port.req && port.we) ##1 (port.req && !port.we && port.addr == $past(port.addr))
         |=> rdata_q == $past(port.wdata, 2);
   endproperty
   a_overwrite: assert property (p_overwrite) else $error("written byte not read back"); // RL6

endmodule : cfa_mem

// *** src/cfa_guard.sv ***
// code flash / eeprom access guard with cpu, in-application and programmer ports
// assumes requesters hold their request until the answer pulse
`timescale 1ns/1ns
module cfa_guard
   import cfa_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // cpu code read path
   input wire logic cpu_req_i,
   input wire logic cpu_table_read_i,
   input wire logic [15:0] cpu_addr_i,
   output logic cpu_rvalid_o,
   output logic [7:0] cpu_rdata_o,
   // in-application access
   input wire logic iap_req_i,
   input wire cfa_op_t iap_op_i,
   input wire cfa_space_t iap_space_i,
   input wire logic [15:0] iap_addr_i,
   input wire logic [7:0] iap_wdata_i,
   input wire logic [1:0] inapp_write_area_select_i,
   output logic iap_done_o,
   output logic iap_ok_o,
   output logic [7:0] iap_rdata_o,
   // two-wire programmer port
   input wire logic prog_clk_i,
   input wire logic prog_data_line_i,
   output logic prog_data_line_o,
   output logic prog_data_line_oe_o
);
   cfa_mem_if #(.AW(MEM_AW)) mem_bus ();

   cfa_mem u_mem (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .port(mem_bus.mem)
   );

   // ----------------------------------------------------------------
   // programmer link, three-stage sync on both wires
   // ----------------------------------------------------------------
   logic [2:0] pclk_s_q, pclk_s_d, pdat_s_q, pdat_s_d;
   logic pclk_lvl_q, pclk_lvl_d, pdat_lvl_q, pdat_lvl_d;
   logic [31:0] shift_q, shift_d, frame_q, frame_d;
   logic [4:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] reply_q, reply_d;
   logic [3:0] reply_cnt_q, reply_cnt_d;
   logic pend_q, pend_d, dout_q, dout_d, doe_q, doe_d;
   logic rise, fall, prog_take, reply_load;
   logic [7:0] reply_value;

   always_comb
   begin
      pclk_s_d = {pclk_s_q[1:0], prog_clk_i};
      pdat_s_d = {pdat_s_q[1:0], prog_data_line_i};
      // a level counts only once stages two and three agree
      pclk_lvl_d = (pclk_s_q[1] == pclk_s_q[2]) ? pclk_s_q[2] : pclk_lvl_q;
      pdat_lvl_d = (pdat_s_q[1] == pdat_s_q[2]) ? pdat_s_q[2] : pdat_lvl_q;
      rise = pclk_lvl_d && !pclk_lvl_q;
      fall = !pclk_lvl_d && pclk_lvl_q;
      shift_d = shift_q;
      bit_cnt_d = bit_cnt_q;
      frame_d = frame_q;
      pend_d = pend_q && !prog_take;
      reply_d = reply_q;
      reply_cnt_d = reply_cnt_q;
      // clock edges during a reply are not frame bits
      if (rise && reply_cnt_q == 4'h0)
      begin
         shift_d = {shift_q[30:0], pdat_lvl_d}; // RL7
         bit_cnt_d = bit_cnt_q + 5'h01;
         if (bit_cnt_q == PROG_FRAME_LAST)
         begin
            frame_d = {shift_q[30:0], pdat_lvl_d};
            pend_d = 1'b1; // set wins over take
         end
      end
      if (reply_load)
      begin
         reply_d = reply_value;
         reply_cnt_d = PROG_REPLY_BITS;
      end
      else if (fall && reply_cnt_q != 4'h0)
      begin
         reply_d = {reply_q[6:0], 1'b0};
         reply_cnt_d = reply_cnt_q - 4'h1;
      end
      dout_d = reply_d[7]; // RL7
      doe_d = (reply_cnt_d != 4'h0);
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         {pclk_s_q, pdat_s_q, pclk_lvl_q, pdat_lvl_q, shift_q, frame_q} <= '0;
         {bit_cnt_q, pend_q, reply_q, reply_cnt_q, dout_q, doe_q} <= '0;
      end
      else
      begin
         {pclk_s_q, pdat_s_q} <= {pclk_s_d, pdat_s_d};
         {pclk_lvl_q, pdat_lvl_q} <= {pclk_lvl_d, pdat_lvl_d};
         {shift_q, frame_q, bit_cnt_q, pend_q} <= {shift_d, frame_d, bit_cnt_d, pend_d};
         {reply_q, reply_cnt_q, dout_q, doe_q} <= {reply_d, reply_cnt_d, dout_d, doe_d};
      end
   end

   assign prog_data_line_o = dout_q;
   assign prog_data_line_oe_o = doe_q;

   // ----------------------------------------------------------------
   // access arbiter: programmer, then in-application, then cpu
   // ----------------------------------------------------------------
   cfa_state_t state_q, state_d;
   cfa_owner_t owner_q, owner_d;
   cfa_op_t op_q, op_d, sel_op;
   cfa_space_t sel_sp;
   logic [15:0] sel_addr;
   logic [7:0] sel_wdata, cmp_q, cmp_d;
   logic zero_q, zero_d, refuse_q, refuse_d, sel_zero, sel_refuse, sel_go;
   logic cpu_rvalid_d, iap_done_d, iap_ok_d;
   logic [7:0] cpu_rdata_d, iap_rdata_d, result;
   logic take_cpu, take_iap;

   assign take_iap = (state_q == ST_IDLE) && !pend_q && iap_req_i;
   assign take_cpu = (state_q == ST_IDLE) && !pend_q && !iap_req_i && cpu_req_i;

   always_comb
   begin
      sel_op = OP_READ;
      sel_sp = SP_CODE;
      sel_addr = 16'h0000;
      sel_wdata = 8'h00;
      sel_zero = 1'b0;
      sel_refuse = 1'b0;
      sel_go = 1'b0;
      prog_take = 1'b0;
      owner_d = owner_q;
      if (state_q == ST_IDLE && pend_q)
      begin
         prog_take = 1'b1;
         sel_go = 1'b1;
         owner_d = OWN_PROG;
         sel_addr = frame_q[23:8];
         sel_wdata = frame_q[7:0];
         unique case (frame_q[31:24])
            PCMD_WRITE_CODE, PCMD_WRITE_UID: sel_op = OP_WRITE;
            PCMD_ERASE_CODE: sel_op = OP_ERASE;
            default: sel_op = OP_READ;
         endcase
         // only the programmer may fill the user id area
         if (frame_q[31:24] inside {PCMD_WRITE_UID, PCMD_READ_UID})
         begin
            sel_sp = SP_UID;
         end
         sel_refuse = !in_space(sel_sp, sel_addr);
         sel_zero = sel_refuse;
      end
      else if (take_iap)
      begin
         sel_go = 1'b1;
         owner_d = OWN_IAP;
         sel_op = iap_op_i; // RL5
         sel_sp = iap_space_i; // RL3
         sel_addr = iap_addr_i;
         sel_wdata = iap_wdata_i;
         sel_zero = !in_space(iap_space_i, iap_addr_i)
            || (iap_space_i == SP_CODE && iap_addr_i <= PROT_LAST); // RL2
         if (iap_op_i == OP_WRITE || iap_op_i == OP_ERASE)
         begin
            unique case (iap_space_i)
               SP_CODE: sel_refuse = !iap_area_ok(iap_addr_i, inapp_write_area_select_i); // RL8
               SP_EE: sel_refuse = !in_space(SP_EE, iap_addr_i); // RL3
               default: sel_refuse = 1'b1; // RL4
            endcase
         end
      end
      else if (take_cpu)
      begin
         sel_go = 1'b1;
         owner_d = OWN_CPU;
         sel_addr = cpu_addr_i;
         sel_zero = !in_space(SP_CODE, cpu_addr_i) // RL1
            || (cpu_table_read_i && cpu_addr_i <= PROT_LAST); // RL2
      end
   end

   always_comb
   begin
      state_d = state_q;
      op_d = op_q;
      cmp_d = cmp_q;
      zero_d = zero_q;
      refuse_d = refuse_q;
      mem_bus.req = 1'b0;
      mem_bus.we = 1'b0;
      mem_bus.addr = mem_index(sel_sp, sel_addr);
      mem_bus.wdata = (sel_op == OP_ERASE) ? ERASED : sel_wdata; // RL5
      cpu_rvalid_d = 1'b0;
      iap_done_d = 1'b0;
      cpu_rdata_d = cpu_rdata_o;
      iap_rdata_d = iap_rdata_o;
      iap_ok_d = iap_ok_o;
      reply_load = 1'b0;
      result = zero_q ? BLOCKED_VALUE : mem_bus.rdata; // RL9
      reply_value = result;
      unique case (state_q)
         ST_IDLE:
         begin
            if (sel_go)
            begin
               // refused or blocked accesses never touch the array
               mem_bus.req = !sel_refuse && !sel_zero;
               mem_bus.we = (sel_op == OP_WRITE || sel_op == OP_ERASE); // RL6
               op_d = sel_op;
               cmp_d = sel_wdata;
               zero_d = sel_zero;
               refuse_d = sel_refuse;
               state_d = ST_ANSWER;
            end
         end
         ST_ANSWER:
         begin
            unique case (owner_q)
               OWN_CPU:
               begin
                  cpu_rvalid_d = 1'b1;
                  cpu_rdata_d = result; // RL9
               end
               OWN_IAP:
               begin
                  iap_done_d = 1'b1;
                  iap_rdata_d = (op_q == OP_READ) ? result : iap_rdata_o;
                  unique case (op_q)
                     OP_EMPTY: iap_ok_d = !zero_q && mem_bus.rdata == ERASED; // RL5
                     OP_VERIFY: iap_ok_d = !zero_q && mem_bus.rdata == cmp_q; // RL5
                     OP_READ: iap_ok_d = !zero_q;
                     default: iap_ok_d = !refuse_q; // RL4
                  endcase
               end
               default: reply_load = (op_q == OP_READ);
            endcase
            state_d = ST_GAP;
         end
         ST_GAP: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_q <= ST_IDLE;
         owner_q <= OWN_CPU;
         op_q <= OP_READ;
         {cmp_q, zero_q, refuse_q, cpu_rvalid_o, cpu_rdata_o} <= '0;
         {iap_done_o, iap_ok_o, iap_rdata_o} <= '0;
      end
      else
      begin
         state_q <= state_d;
         owner_q <= owner_d;
         op_q <= op_d;
         {cmp_q, zero_q, refuse_q} <= {cmp_d, zero_d, refuse_d};
         {cpu_rvalid_o, cpu_rdata_o} <= {cpu_rvalid_d, cpu_rdata_d};
         {iap_done_o, iap_ok_o, iap_rdata_o} <= {iap_done_d, iap_ok_d, iap_rdata_d};
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_decode;
      take_cpu && cpu_addr_i > CODE_LAST |-> ##2 cpu_rvalid_o && cpu_rdata_o == 8'h00;
   endproperty
   a_decode: assert property (p_decode) else $error("code read past end not zero"); // RL1

   property p_block;
      take_cpu && cpu_table_read_i && cpu_addr_i <= PROT_LAST
         |-> !mem_bus.req ##2 cpu_rvalid_o && cpu_rdata_o == 8'h00;
   endproperty
   a_block: assert property (p_block) else $error("protected table read leaked"); // RL2

   property p_ee_range;
      take_iap && iap_space_i == SP_EE && iap_op_i == OP_WRITE && iap_addr_i > EE_LAST
         |-> ##2 iap_done_o && !iap_ok_o;
   endproperty
   a_ee_range: assert property (p_ee_range) else $error("eeprom write past end accepted"); // RL3

   property p_uid_ro;
      take_iap && iap_space_i == SP_UID && iap_op_i inside {OP_WRITE, OP_ERASE}
         |-> !mem_bus.req ##2 iap_done_o && !iap_ok_o;
   endproperty
   a_uid_ro: assert property (p_uid_ro) else $error("user id write not refused"); // RL4

   property p_ops_done;
      take_iap && iap_op_i inside {OP_EMPTY, OP_VERIFY} |-> !iap_done_o ##1 !iap_done_o ##1 iap_done_o;
   endproperty
   a_ops_done: assert property (p_ops_done) else $error("check op not answered in 2"); // RL5

   property p_prog_take;
      $rose(pend_q) |-> ##[1:3] !pend_q;
   endproperty
   a_prog_take: assert property (p_prog_take) else $error("programmer frame not served"); // RL7

   property p_area_none;
      take_iap && iap_space_i == SP_CODE && iap_op_i == OP_WRITE
         && inapp_write_area_select_i == AREA_NONE |-> !mem_bus.req ##2 !iap_ok_o;
   endproperty
   a_area_none: assert property (p_area_none) else $error("write with area none accepted"); // RL8

   property p_area_half;
      take_iap && iap_space_i == SP_CODE && iap_op_i == OP_WRITE
         && inapp_write_area_select_i == AREA_HALF
         |-> mem_bus.req == (iap_addr_i >= AREA_HALF_BASE && iap_addr_i <= CODE_LAST)
         ##2 iap_ok_o == $past(mem_bus.req, 2);
   endproperty
   a_area_half: assert property (p_area_half) else $error("half area window wrong"); // RL8

endmodule : cfa_guard

// *** testbench/cfa_prog_model.sv ***
// two-wire programmer model: shifts frames in msb first, collects read replies
// assumes the device samples its clock pin through a synchroniser
`timescale 1ns/1ns
module cfa_prog_model
   import cfa_pkg::*;
(
   // core clock reference
   input wire logic core_clk_i,
   // device side of the data line
   input wire logic dev_data_i,
   input wire logic dev_oe_i,
   // wire levels seen by the device
   output logic prog_clk_o,
   output logic line_o,
   // collected reply byte, one-cycle strobe
   output logic [7:0] rx_byte_o,
   output logic rx_stb_o
);
   // five core cycles, above the four-cycle minimum half period
   localparam int HALF_NS = 200;
   logic pm_oe = 1'b0;
   logic pm_d = 1'b0;

   initial
   begin
      prog_clk_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_stb_o = 1'b0;
   end

   // --------------------
   // wire level
   // --------------------
   // no pull: a released line shows the inverse of the device data output
   assign line_o = dev_oe_i ? dev_data_i : (pm_oe ? pm_d : ~dev_data_i);

   // --------------------
   // frame and reply
   // --------------------
   task automatic send_frame(input logic [7:0] cmd, input logic [15:0] addr,
                             input logic [7:0] data, input logic rd);
      logic [31:0] fr;
      int n;
      fr = {cmd, addr, data};
      @(posedge core_clk_i);
      #5;
      pm_oe = 1'b1;
      for (int i = 31; i >= 0; i--)
      begin
         pm_d = fr[i];
         #HALF_NS prog_clk_o = 1'b1;
         // a read keeps the clock high: no fall before the reply
         #HALF_NS prog_clk_o = (i == 0 && rd);
         #HALF_NS;
      end
      pm_oe = 1'b0;
      if (rd)
      begin
         n = 0;
         while (dev_oe_i !== 1'b1 && n < 40)
         begin
            @(posedge core_clk_i);
            n++;
         end
         #(HALF_NS + 5);
         for (int b = 7; b >= 0; b--)
         begin
            rx_byte_o[b] = line_o;
            prog_clk_o = 1'b0;
            #HALF_NS prog_clk_o = (b > 0);
            #HALF_NS;
         end
         @(posedge core_clk_i);
         #5;
         rx_stb_o = 1'b1;
         @(posedge core_clk_i);
         #5;
         rx_stb_o = 1'b0;
      end
      repeat (20) @(posedge core_clk_i);
   endtask : send_frame
endmodule : cfa_prog_model

// *** testbench/code_flash_access_guard_bench.sv ***
// self-checking bench for the access guard: cpu, iap and programmer paths
// assumes cfa_guard holds its own backing memory
`timescale 1ns/1ns
module code_flash_access_guard_bench
   import cfa_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic reset_n = 1'b0;
   logic cpu_req = 1'b0, cpu_tbl = 1'b0, cpu_rvalid, iap_req = 1'b0, iap_done, iap_ok;
   logic [15:0] cpu_addr = 16'h0000, iap_addr = 16'h0000, a;
   logic [7:0] cpu_rdata, iap_wdata = 8'h00, iap_rdata, rx_byte;
   logic [9:0] exp_i;
   logic [1:0] area_sel = 2'h0;
   cfa_op_t iap_op = OP_READ;
   cfa_space_t iap_space = SP_CODE;
   logic prog_clk, prog_line, dev_d, dev_oe, rx_stb;
   logic [7:0] cpu_q[$], prog_q[$], shadow[int];
   logic [9:0] iap_q[$];
   logic [15:0] area_addr [5] = '{16'h3BFF, 16'h3C00, 16'h3DFF, 16'h3E00, 16'h3FFF};
   int bad_count = 0, tests_run = 0;

   always #20 core_clk_i = ~core_clk_i;

   cfa_guard i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n), .cpu_req_i(cpu_req),
      .cpu_table_read_i(cpu_tbl), .cpu_addr_i(cpu_addr), .cpu_rvalid_o(cpu_rvalid),
      .cpu_rdata_o(cpu_rdata), .iap_req_i(iap_req), .iap_op_i(iap_op),
      .iap_space_i(iap_space), .iap_addr_i(iap_addr), .iap_wdata_i(iap_wdata),
      .inapp_write_area_select_i(area_sel), .iap_done_o(iap_done), .iap_ok_o(iap_ok),
      .iap_rdata_o(iap_rdata), .prog_clk_i(prog_clk), .prog_data_line_i(prog_line),
      .prog_data_line_o(dev_d), .prog_data_line_oe_o(dev_oe));

   cfa_prog_model i_prog (.core_clk_i(core_clk_i), .dev_data_i(dev_d), .dev_oe_i(dev_oe),
      .prog_clk_o(prog_clk), .line_o(prog_line), .rx_byte_o(rx_byte), .rx_stb_o(rx_stb));

   // --------------------
   // compare and bookkeeping
   // --------------------
   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_byte

   task automatic cmp_flag(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_flag

   function automatic int skey(input cfa_space_t sp, input logic [15:0] ad);
      return int'(sp) * 65536 + int'(ad);
   endfunction : skey

   task automatic end_test(input string name);
      $display("test %s done, checks %0d", name, tests_run);
   endtask : end_test

   task automatic finish_test;
      bad_count += cpu_q.size() + iap_q.size() + prog_q.size();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // --------------------
   // drivers: note the expected answer, then make the request
   // --------------------
   task automatic wait_high(ref logic s);
      int n;
      n = 0;
      do
         @(posedge core_clk_i);
      while (s !== 1'b1 && ++n < 50);
      #5;
   endtask : wait_high

   task automatic cpu_read(input logic [15:0] ad, input logic tbl, input logic [7:0] exp);
      cpu_q.push_back(exp);
      @(posedge core_clk_i);
      #5;
      cpu_req = 1'b1;
      cpu_tbl = tbl;
      cpu_addr = ad;
      wait_high(cpu_rvalid);
      cpu_req = 1'b0;
   endtask : cpu_read

   task automatic area_set(input logic [1:0] s);
      @(posedge core_clk_i);
      #5;
      area_sel = s;
   endtask : area_set

   task automatic iap_do(input cfa_op_t op, input cfa_space_t sp, input logic [15:0] ad,
                         input logic [7:0] wd);
      logic inr, rdok, wrok, ok;
      logic [7:0] old;
      inr = (sp == SP_CODE) ? ad <= 16'h3FFF : (sp == SP_EE) ? ad <= 16'h007F : ad <= 16'h000F;
      rdok = inr && !(sp == SP_CODE && ad <= 16'h00FF);
      wrok = (sp == SP_EE) ? inr : (sp == SP_UID) ? 1'b0 : (area_sel == 2'h3) ? inr :
             (area_sel == 2'h2) ? (ad >= 16'h3C00 && inr) :
             (area_sel == 2'h1) ? (ad >= 16'h3E00 && inr) : 1'b0;
      old = shadow.exists(skey(sp, ad)) ? shadow[skey(sp, ad)] : 8'hxx;
      case (op)
         OP_READ: ok = rdok;
         OP_EMPTY: ok = rdok && (old === 8'hFF);
         OP_VERIFY: ok = rdok && (old === wd);
         default: ok = wrok;
      endcase
      if (ok && op inside {OP_WRITE, OP_ERASE})
         shadow[skey(sp, ad)] = (op == OP_ERASE) ? 8'hFF : wd;
      iap_q.push_back({op == OP_READ, ok, ok ? old : 8'h00});
      @(posedge core_clk_i);
      #5;
      iap_req = 1'b1;
      iap_op = op;
      iap_space = sp;
      iap_addr = ad;
      iap_wdata = wd;
      wait_high(iap_done);
      iap_req = 1'b0;
   endtask : iap_do

   task automatic prog_do(input logic [7:0] cmd, input logic [15:0] ad, input logic [7:0] d);
      if (cmd == PCMD_WRITE_CODE && ad <= 16'h3FFF)
         shadow[skey(SP_CODE, ad)] = d;
      if (cmd == PCMD_WRITE_UID && ad <= 16'h000F)
         shadow[skey(SP_UID, ad)] = d;
      if (cmd == PCMD_READ_CODE)
         prog_q.push_back(ad <= 16'h3FFF ? shadow[skey(SP_CODE, ad)] : 8'h00);
      if (cmd == PCMD_READ_UID)
         prog_q.push_back(shadow[skey(SP_UID, ad)]);
      i_prog.send_frame(cmd, ad, d, cmd == PCMD_READ_CODE || cmd == PCMD_READ_UID);
   endtask : prog_do

   // --------------------
   // monitor: oldest note against each answer that appears
   // --------------------
   always @(posedge core_clk_i)
   begin
      if (cpu_rvalid === 1'b1)
      begin
         cmp_byte("cpu_rdata", cpu_q.size() ? cpu_q.pop_front() : 8'hxx, cpu_rdata);
      end
      if (iap_done === 1'b1)
      begin
         exp_i = iap_q.size() ? iap_q.pop_front() : 10'bx;
         cmp_flag("iap_ok", exp_i[8], iap_ok);
         if (exp_i[9] === 1'b1)
            cmp_byte("iap_rdata", exp_i[7:0], iap_rdata);
      end
      if (rx_stb === 1'b1)
      begin
         cmp_byte("prog_reply", prog_q.size() ? prog_q.pop_front() : 8'hxx, rx_byte);
      end
   end

   initial
   begin
      repeat (40000) @(posedge core_clk_i);
      bad_count++;
      finish_test();
   end

   // --------------------
   // tests
   // --------------------
   initial
   begin
      void'($urandom(32'hfe25));
      repeat (10) @(posedge core_clk_i);
      #5;
      reset_n = 1'b1;
      prog_do(PCMD_WRITE_CODE, 16'h0000, 8'hA5);
      prog_do(PCMD_WRITE_CODE, 16'h00FF, 8'h3C);
      prog_do(PCMD_WRITE_CODE, 16'h0100, 8'h96);
      prog_do(PCMD_WRITE_CODE, 16'h3FFF, 8'h5A);
      prog_do(PCMD_WRITE_UID, 16'h0003, 8'hC3);
      prog_do(PCMD_READ_CODE, 16'h0000, 8'h00);
      prog_do(PCMD_READ_CODE, 16'h4000, 8'h00);
      prog_do(PCMD_READ_UID, 16'h0003, 8'h00);
      end_test("programmer");
      cpu_read(16'h0000, 1'b1, 8'h00);
      cpu_read(16'h00FF, 1'b1, 8'h00);
      cpu_read(16'h0100, 1'b1, 8'h96);
      cpu_read(16'h0000, 1'b0, 8'hA5);
      cpu_read(16'h3FFF, 1'b1, 8'h5A);
      cpu_read(16'h4000, 1'b0, 8'h00);
      iap_do(OP_READ, SP_CODE, 16'h00FF, 8'h00);
      end_test("cpu_reads");
      // code 3 first: later reads find known bytes
      for (int s = 0; s < 4; s++)
      begin
         area_set(2'((s + 3) % 4));
         foreach (area_addr[k])
         begin
            iap_do(OP_WRITE, SP_CODE, area_addr[k], 8'($urandom));
            iap_do(OP_READ, SP_CODE, area_addr[k], 8'h00);
         end
      end
      end_test("area_select");
      area_set(2'h3);
      iap_do(OP_ERASE, SP_CODE, 16'h2000, 8'h00);
      iap_do(OP_EMPTY, SP_CODE, 16'h2000, 8'h00);
      iap_do(OP_VERIFY, SP_CODE, 16'h2000, 8'hFF);
      iap_do(OP_WRITE, SP_CODE, 16'h2000, 8'h12);
      iap_do(OP_WRITE, SP_CODE, 16'h2000, 8'h34);
      iap_do(OP_EMPTY, SP_CODE, 16'h2000, 8'h00);
      iap_do(OP_VERIFY, SP_CODE, 16'h2000, 8'h34);
      iap_do(OP_VERIFY, SP_CODE, 16'h2000, 8'h35);
      iap_do(OP_READ, SP_CODE, 16'h2000, 8'h00);
      iap_do(OP_EMPTY, SP_CODE, 16'h0010, 8'h00);
      end_test("flash_ops");
      iap_do(OP_WRITE, SP_EE, 16'h0000, 8'($urandom));
      iap_do(OP_WRITE, SP_EE, 16'h007F, 8'($urandom));
      iap_do(OP_WRITE, SP_EE, 16'h0000, 8'($urandom));
      iap_do(OP_READ, SP_EE, 16'h0000, 8'h00);
      iap_do(OP_READ, SP_EE, 16'h007F, 8'h00);
      iap_do(OP_WRITE, SP_EE, 16'h0080, 8'h77);
      iap_do(OP_READ, SP_EE, 16'h0080, 8'h00);
      iap_do(OP_READ, SP_UID, 16'h0003, 8'h00);
      iap_do(OP_WRITE, SP_UID, 16'h0003, 8'h00);
      iap_do(OP_ERASE, SP_UID, 16'h0003, 8'h00);
      iap_do(OP_READ, SP_UID, 16'h0003, 8'h00);
      prog_do(PCMD_READ_UID, 16'h0003, 8'h00);
      end_test("eeprom_uid");
      for (int k = 0; k < 16; k++)
      begin
         a = 16'h0100 + 16'($urandom_range(16'h3EFF));
         iap_do(OP_WRITE, SP_CODE, a, 8'($urandom));
         cpu_read(a, 1'(k % 2), shadow[skey(SP_CODE, a)]);
      end
      end_test("random");
      repeat (5) @(posedge core_clk_i);
      finish_test();
   end
endmodule : code_flash_access_guard_bench
